// ---- core/e1fg_events.sv ----
// e1fg_events: event flags, interrupt and national-bit registers of one
// e1 transmit frame generator channel.
// assumes a synchronous byte register port and one bit strobe per line bit.
//
// Overview of operation
// RQ1: the interrupt pin shows only latched flags whose enable in bits 4 to 1 is set.
// RQ2: reading the status register clears all four event flags.
// RQ3: the signaling multiframe flag sets at the end of frame 0 of an aligned signaling multiframe.
// RQ4: the frame-alignment flag sets at each boundary of a fas frame while framing is generated; the code sets it only at the end of each even frame.
// RQ5: the crc multiframe flag sets at the end of frame 0 of each crc-4 multiframe.
// RQ6: the sub-multiframe flag sets at the end of frame 0 of each crc-4 sub multiframe.
// RQ7: the position select maps 011 to 111 onto sa4 to sa8, lower codes are reserved.
// RQ8: each codeword bit replaces its sa bit only when its own enable is set and framing is active.
// RQ9: the four codeword bits go into the selected sa position across one sub multiframe.
// RQ10: a codeword written in the first sub multiframe goes out in the second.
// RQ11: a codeword written in the second sub multiframe goes out in the next first one.
// RQ12: with passthrough set, data passes unchanged and no bit is substituted.
// RQ13: with international-bit replacement off, the stream bits are kept.
// RQ14: crc multiframe timing is active only while its enable control is set.
// RQ15: the active-low interrupt holds while an enabled flag is set and releases after the read.
`timescale 1ns/10ps
`default_nettype none

module e1fg_events (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // framing controls
  input wire e1fg_pkg::e1fg_ctrl_t FRAME_CTRL,
  // transmit stream
  input wire logic BIT_STROBE,
  input wire logic TX_DATA_IN,
  output logic TX_DATA_OUT,
  // interrupt
  output logic INT_N
);
  import e1fg_pkg::*;

  e1fg_pos_t pos;
  logic [3:0] irq_en;
  logic [3:0] flags;
  logic [2:0] sa_sel;
  logic [3:0] cw_en;
  logic [3:0] cw_val;
  logic [3:0] set_vec;
  logic [3:0] next_flags;
  logic [7:0] next_rdata;
  logic frame_end;
  logic crc_active;
  logic status_read;
  e1fg_natcfg_t natcfg;

  // ----------------------------------------
  // frame position
  // ----------------------------------------
  // free-running from reset; the generator's bit 0 of frame 0 follows reset
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      pos <= '0;
    else if (BIT_STROBE)
    begin
      pos.bit_pos <= pos.bit_pos + 8'h01;
      if (pos.bit_pos == BIT_LAST)
        pos.frame <= pos.frame + 4'h1;
    end
  end

  assign frame_end = BIT_STROBE && pos.bit_pos == BIT_LAST;
  // crc generation is ignored under passthrough or intl-bit replacement off
  assign crc_active = FRAME_CTRL.crc_multiframe_gen_on && !FRAME_CTRL.framing_passthrough
    && !FRAME_CTRL.intl_bit_replace_off; // RQ14

  // ----------------------------------------
  // event detection
  // ----------------------------------------
  always_comb
  begin
    set_vec = 4'h0;
    set_vec[FLAG_FAS] = frame_end && !FRAME_CTRL.framing_passthrough
      && !pos.frame[0]; // RQ4
    set_vec[FLAG_MF] = frame_end && crc_active && pos.frame == FRAME_FIRST; // RQ5
    set_vec[FLAG_SMF] = frame_end && crc_active && pos.frame[2:0] == SMF_FIRST; // RQ6
    set_vec[FLAG_SIG] = frame_end && crc_active && FRAME_CTRL.sig_multiframe_gen_on
      && pos.frame == FRAME_FIRST; // RQ3
  end

  assign status_read = REG_RD && REG_ADDR == ADDR_EVENT_STATUS;

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // a new event in the reading cycle survives the clear
  always_comb
  begin
    next_flags = status_read ? EVT_STATUS_RST : flags; // RQ2
    next_flags = next_flags | set_vec;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      flags <= EVT_STATUS_RST;
    else
      flags <= next_flags;
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      irq_en <= EVT_ENABLE_RST;
    else if (REG_WR && REG_ADDR == ADDR_EVENT_ENABLE)
      irq_en <= REG_WDATA[EVT_MSB:EVT_LSB];
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      sa_sel <= NATBIT_SEL_RST;
    else if (REG_WR && REG_ADDR == ADDR_NATBIT_SEL)
      sa_sel <= REG_WDATA[SEL_MSB:SEL_LSB];
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      cw_en <= CW_EN_RST;
      cw_val <= CW_VAL_RST;
    end
    else if (REG_WR && REG_ADDR == ADDR_NATBIT_CW)
    begin
      cw_en <= REG_WDATA[CW_EN_MSB:CW_EN_LSB];
      cw_val <= REG_WDATA[CW_VAL_MSB:CW_VAL_LSB];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // reserved bits and unmapped offsets read as zero
  always_comb
  begin
    next_rdata = RDATA_RST;
    unique case (REG_ADDR)
      ADDR_EVENT_ENABLE: next_rdata[EVT_MSB:EVT_LSB] = irq_en;
      ADDR_EVENT_STATUS: next_rdata[EVT_MSB:EVT_LSB] = flags;
      ADDR_NATBIT_SEL: next_rdata[SEL_MSB:SEL_LSB] = sa_sel;
      ADDR_NATBIT_CW: next_rdata = {cw_en, cw_val};
      default: next_rdata = RDATA_RST;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      REG_RDATA <= RDATA_RST;
    else if (REG_RD)
      REG_RDATA <= next_rdata;
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // follows the flags one cycle later so the pin stays a flop output
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      INT_N <= 1'b1;
    else
      INT_N <= ~|(flags & irq_en); // RQ1 RQ15
  end

  // ----------------------------------------
  // national bit insertion
  // ----------------------------------------
  assign natcfg = '{natbit_position_sel: sa_sel, natbit_bit_enable: cw_en,
    natbit_codeword: cw_val};

  e1fg_natbit u_natbit (
    .clk(CLOCK),
    .rst_n(RST_N),
    .bit_strobe(BIT_STROBE),
    .din(TX_DATA_IN),
    .pos(pos),
    .ctrl(FRAME_CTRL),
    .cfg(natcfg),
    .dout(TX_DATA_OUT)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_int_gating: assert property ( // RQ1
    ##1 INT_N == !(|($past(flags) & $past(irq_en))))
    else $error("interrupt pin disagrees with enabled flags");
  a_int_release: assert property ( // RQ15
    status_read && set_vec == 4'h0 |=> ##1 INT_N)
    else $error("interrupt not released after status read");
  a_read_clears: assert property ( // RQ2
    status_read && set_vec == 4'h0 |=> flags == EVT_STATUS_RST)
    else $error("status read did not clear flags");
  a_sig_flag: assert property ( // RQ3
    frame_end && crc_active && FRAME_CTRL.sig_multiframe_gen_on && pos.frame == FRAME_FIRST
    |=> flags[FLAG_SIG])
    else $error("signaling multiframe flag missed");
  a_fas_flag: assert property ( // RQ4
    frame_end && !FRAME_CTRL.framing_passthrough && !pos.frame[0] |=> flags[FLAG_FAS])
    else $error("frame alignment flag missed");
  a_mf_flag: assert property ( // RQ5
    frame_end && crc_active && pos.frame == FRAME_FIRST |=> flags[FLAG_MF] && flags[FLAG_SMF])
    else $error("crc multiframe flag missed");
  a_smf_flag: assert property ( // RQ6
    frame_end && crc_active && pos.frame[2:0] == SMF_FIRST |=> flags[FLAG_SMF])
    else $error("sub-multiframe flag missed");
  a_crc_off_quiet: assert property ( // RQ14
    !FRAME_CTRL.crc_multiframe_gen_on || FRAME_CTRL.framing_passthrough
    || FRAME_CTRL.intl_bit_replace_off
    |-> !set_vec[FLAG_MF] && !set_vec[FLAG_SMF] && !set_vec[FLAG_SIG])
    else $error("multiframe event without crc generation");

endmodule

`default_nettype wire

// ---- core/e1fg_natbit.sv ----
// e1fg_natbit: national-bit codeword inserter on the serial transmit stream.
// assumes frame position and bit strobe come from the event core counters.
`timescale 1ns/10ps
`default_nettype none

module e1fg_natbit (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // stream and timing
  input wire logic bit_strobe,
  input wire logic din,
  input wire e1fg_pkg::e1fg_pos_t pos,
  // configuration
  input wire e1fg_pkg::e1fg_ctrl_t ctrl,
  input wire e1fg_pkg::e1fg_natcfg_t cfg,
  // output
  output logic dout
);
  import e1fg_pkg::*;

  logic [3:0] act_en;
  logic [3:0] act_val;
  logic smf_end;
  logic next_dout;
  logic [1:0] slot;
  logic sub_ok;
  logic hit;

  assign smf_end = bit_strobe && pos.bit_pos == BIT_LAST && pos.frame[2:0] == SMF_LAST;
  assign slot = cw_slot(pos.frame[2:1]);
  assign sub_ok = !ctrl.framing_passthrough && !ctrl.intl_bit_replace_off; // RQ12 RQ13
  assign hit = sub_ok && natbit_sel_valid(cfg.natbit_position_sel) && pos.frame[0]
    && pos.bit_pos == natbit_bit_index(cfg.natbit_position_sel); // RQ7

  // --------------------------------
  // codeword staging
  // --------------------------------
  // loading only at sub-multiframe edges keeps a word from being split
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      act_en <= CW_EN_RST;
      act_val <= CW_VAL_RST;
    end
    else if (smf_end)
    begin
      act_en <= cfg.natbit_bit_enable; // RQ10 RQ11
      act_val <= cfg.natbit_codeword;
    end
  end

  // --------------------------------
  // substitution
  // --------------------------------
  always_comb
  begin
    next_dout = din;
    if (hit && act_en[slot])
      next_dout = act_val[slot]; // RQ8 RQ9
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dout <= 1'b0;
    else if (bit_strobe)
      dout <= next_dout;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_passthrough_data: assert property ( // RQ12
    bit_strobe && ctrl.framing_passthrough |=> dout == $past(din))
    else $error("passthrough altered data");
  a_intl_off_data: assert property ( // RQ13
    bit_strobe && ctrl.intl_bit_replace_off |=> dout == $past(din))
    else $error("intl bit off altered data");
  a_cw_staging: assert property ( // RQ10
    smf_end |=> act_val == $past(cfg.natbit_codeword) && act_en == $past(cfg.natbit_bit_enable))
    else $error("codeword not staged at sub-multiframe edge");
  a_cw_hold: assert property ( // RQ11
    !smf_end |=> $stable(act_val) && $stable(act_en))
    else $error("staged codeword changed mid sub-multiframe");
  a_cw_insert: assert property ( // RQ8
    bit_strobe && hit && act_en[slot] |=> dout == $past(act_val[slot]))
    else $error("enabled codeword bit not inserted");
  a_cw_skip: assert property ( // RQ9
    bit_strobe && !(hit && act_en[slot]) |=> dout == $past(din))
    else $error("bit replaced outside selected position");

endmodule

`default_nettype wire

// ---- include/e1fg_pkg.sv ----
// e1fg_pkg: constants and carrier types for the e1 transmit framer event
// and national-bit block; shared by the event/register core and the inserter.
package e1fg_pkg;

  // ----------------------------------------
  // register map (documented byte offsets)
  // ----------------------------------------
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h44;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h45;
  localparam logic [7:0] ADDR_NATBIT_SEL = 8'h46;
  localparam logic [7:0] ADDR_NATBIT_CW = 8'h47;

  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int EVT_LSB = 1;
  localparam int EVT_MSB = 4;
  localparam int SEL_LSB = 5;
  localparam int SEL_MSB = 7;
  localparam int CW_VAL_LSB = 0;
  localparam int CW_VAL_MSB = 3;
  localparam int CW_EN_LSB = 4;
  localparam int CW_EN_MSB = 7;
  localparam logic [3:0] EVT_ENABLE_RST = 4'h0;
  localparam logic [3:0] EVT_STATUS_RST = 4'h0;
  localparam logic [2:0] NATBIT_SEL_RST = 3'h0;
  localparam logic [3:0] CW_EN_RST = 4'h0;
  localparam logic [3:0] CW_VAL_RST = 4'hf;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // event flag index inside the 4-bit field (register bit = index + 1)
  localparam int FLAG_SMF = 0;
  localparam int FLAG_MF = 1;
  localparam int FLAG_FAS = 2;
  localparam int FLAG_SIG = 3;

  // ----------------------------------------
  // frame structure
  // ----------------------------------------
  localparam logic [7:0] BIT_LAST = 8'hff;
  localparam logic [3:0] FRAME_FIRST = 4'h0;
  localparam logic [2:0] SMF_FIRST = 3'h0;
  localparam logic [2:0] SMF_LAST = 3'h7;
  localparam logic [2:0] SEL_SA4 = 3'h3;
  localparam logic [1:0] CW_TOP = 2'h3;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic framing_passthrough;
    logic intl_bit_replace_off;
    logic crc_multiframe_gen_on;
    logic sig_multiframe_gen_on;
  } e1fg_ctrl_t;

  typedef struct packed {
    logic [3:0] frame;
    logic [7:0] bit_pos;
  } e1fg_pos_t;

  typedef struct packed {
    logic [2:0] natbit_position_sel;
    logic [3:0] natbit_bit_enable;
    logic [3:0] natbit_codeword;
  } e1fg_natcfg_t;

  // ----------------------------------------
  // decoders
  // ----------------------------------------
  function automatic logic natbit_sel_valid(input logic [2:0] sel);
    return sel >= SEL_SA4;
  endfunction

  // ts0 bit index (0 = first bit) of the selected sa position
  function automatic logic [7:0] natbit_bit_index(input logic [2:0] sel);
    return {5'h00, sel};
  endfunction

  // register bit of codeword element k (element 0 sits in the top bit)
  function automatic logic [1:0] cw_slot(input logic [1:0] k);
    return CW_TOP - k;
  endfunction

endpackage

// ---- verif/e1_tx_frame_gen_events_natbits_tb.sv ----
// e1_tx_frame_gen_events_natbits_tb: self-checking bench for e1fg_events.
// assumes e1fg_pkg and the line receiver model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module e1_tx_frame_gen_events_natbits_tb;
  import e1fg_pkg::*;
  logic clock;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  e1fg_ctrl_t ctrl;
  logic strobe;
  logic din;
  logic dout;
  logic int_n;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  e1fg_events i_dut (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .FRAME_CTRL(ctrl), .BIT_STROBE(strobe), .TX_DATA_IN(din), .TX_DATA_OUT(dout),
    .INT_N(int_n));
  e1fg_line_rx i_line (.clk(clock), .rst_n(rst_n), .strobe(strobe), .line_bit(dout));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // the run needs about 64k cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 100000)
    begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim();
  begin
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
  begin
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  end
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata;
  end
  endtask

  // bounded wait for a line position; the cycle ceiling catches a miss
  task automatic wait_at(input logic [3:0] f, input logic [7:0] b);
    int n;
  begin
    n = 0;
    while (i_line.pos !== {f, b} && n < 5000)
    begin
      @(negedge clock);
      n++;
    end
  end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic regs();
    logic [7:0] d;
    logic [7:0] ra [5] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h48};
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'h00};
    logic [7:0] wv [5] = '{8'h1e, 8'h00, 8'he0, 8'hff, 8'h00};
  begin
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i], d);
      check(d, rv[i], "reset value");
    end
    for (int i = 0; i < 5; i++)
    begin
      // the status register is read-only, and 0x48 is unmapped here
      if (i != 1)
        wr(ra[i], 8'hff);
      rd(ra[i], d);
      check(d, wv[i], "readback");
    end
  end
  endtask

  task automatic ev(input e1fg_ctrl_t c, input logic [7:0] en, input logic [3:0] f_clr,
    input logic [3:0] f_rd, input logic [7:0] exp, input logic exp_int);
    logic [7:0] d;
  begin
    @(negedge clock);
    ctrl = c;
    wr(ADDR_EVENT_ENABLE, en);
    wait_at(f_clr, 8'h04);
    rd(ADDR_EVENT_STATUS, d);
    wait_at(f_rd, 8'h04);
    check({7'h00, int_n}, {7'h00, exp_int}, "interrupt level");
    rd(ADDR_EVENT_STATUS, d);
    check(d, exp, "event flags");
    rd(ADDR_EVENT_STATUS, d);
    check(d, 8'h00, "flags after read");
    check({7'h00, int_n}, 8'h01, "interrupt release");
  end
  endtask

  task automatic nb(input e1fg_ctrl_t c, input logic [2:0] sel, input logic [2:0] idx,
    input logic [7:0] cw, input logic [3:0] exp);
  begin
    @(negedge clock);
    ctrl = c;
    wr(ADDR_NATBIT_SEL, {sel, 5'h00});
    wait_at(4'h2, 8'h00);
    wr(ADDR_NATBIT_CW, cw);
    wait_at(4'h0, 8'h01);
    for (int k = 0; k < 4; k++)
      check({7'h00, i_line.ts0[9 + 2 * k][idx]}, {7'h00, exp[3 - k]}, "sa bit");
  end
  endtask

  // a second write in the same multiframe must not disturb the first codeword
  task automatic nb_late();
    logic [3:0] smf2_word = 4'ha;
    logic [3:0] smf1_word = 4'h5;
  begin
    @(negedge clock);
    ctrl = 4'h0;
    wr(ADDR_NATBIT_SEL, 8'h80);
    wait_at(4'h2, 8'h00);
    wr(ADDR_NATBIT_CW, 8'hfa);
    wait_at(4'ha, 8'h00);
    wr(ADDR_NATBIT_CW, 8'hf5);
    wait_at(4'h8, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      check({7'h00, i_line.ts0[9 + 2 * k][4]}, {7'h00, smf2_word[3 - k]}, "smf2 word");
      check({7'h00, i_line.ts0[1 + 2 * k][4]}, {7'h00, smf1_word[3 - k]}, "smf1 word");
    end
  end
  endtask

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctrl = 4'h0;
    din = 1'b1;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    regs();
    ev(4'h3, 8'h1e, 4'hf, 4'h1, 8'h1e, 1'b0);
    ev(4'h3, 8'h02, 4'h1, 4'h3, 8'h08, 1'b1);
    ev(4'h3, 8'h02, 4'h7, 4'h9, 8'h0a, 1'b0);
    ev(4'h2, 8'h1e, 4'hf, 4'h1, 8'h0e, 1'b0);
    ev(4'h0, 8'h1e, 4'hf, 4'h1, 8'h08, 1'b0);
    for (int s = 3; s < 8; s++)
      nb(4'h0, s[2:0], s[2:0], 8'hf6, 4'h6);
    nb(4'h0, 3'h3, 3'h3, 8'h80, 4'h7);
    nb(4'h0, 3'h3, 3'h3, 8'h10, 4'he);
    nb(4'h0, 3'h2, 3'h3, 8'hf0, 4'hf);
    // a low stream under an all-ones codeword tells pass-through from insertion
    din = 1'b0;
    nb(4'h8, 3'h3, 3'h3, 8'hff, 4'h0);
    nb(4'h4, 3'h3, 3'h3, 8'hff, 4'h0);
    din = 1'b1;
    nb_late();
    end_sim();
  end
endmodule
`default_nettype wire

// ---- verif/e1fg_line_rx.sv ----
// e1fg_line_rx: line-side receiver model for the framer output.
// assumes the framer counts bit 0 of frame 0 at the first strobe after reset.
`timescale 1ns/10ps
`default_nettype none

module e1fg_line_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // line side
  output logic strobe,
  input wire logic line_bit
);
  logic [11:0] pos;
  logic [11:0] last_pos;
  logic seen;
  logic [7:0] ts0 [16];

  // a continuous line: one strobe per clock keeps the run short
  always @(negedge clk)
  begin
    strobe <= rst_n;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pos <= 12'h000;
      seen <= 1'b0;
    end
    else if (strobe)
    begin
      // the bit launched at the previous strobe has settled by now
      if (seen && last_pos[7:0] < 8'h08)
        ts0[last_pos[11:8]][last_pos[2:0]] <= line_bit;
      last_pos <= pos;
      pos <= pos + 12'h001;
      seen <= 1'b1;
    end
  end
endmodule
`default_nettype wire
